// ==== src/ulp_pkg.sv ====
// Purpose: Shared constants for the loss-of-load (undercurrent) trip block.
// Assumes: 50 MHz system clock, 32-bit register port, byte offsets.
// Notes: Percent settings are whole percent; delays are milliseconds.
package ulp_pkg;

  // Clock and tick timing.
  localparam int CLK_PERIOD_NS = 20;
  localparam int TICK_PERIOD_NS = 1000000;
  localparam int TICK_CYCLES_DEF = TICK_PERIOD_NS / CLK_PERIOD_NS;

  // Widths.
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int MAG_W = 16;
  localparam int PCT_W = 8;
  localparam int MS_W = 16;
  localparam int THR_W = 16;
  localparam int CMP_W = 24;
  localparam int NUM_PHASES = 3;

  // Register byte offsets.
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_RATIO = 8'h04;
  localparam logic [7:0] OFS_START = 8'h08;
  localparam logic [7:0] OFS_IDLE = 8'h0C;
  localparam logic [7:0] OFS_DELAY = 8'h10;
  localparam logic [7:0] OFS_STATE = 8'h14;
  localparam logic [7:0] OFS_IRQ_STAT = 8'h18;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h1C;

  // Control register fields.
  localparam int CTRL_OPER_BIT = 0;
  localparam int CTRL_STONLY_BIT = 1;

  // State register fields.
  localparam int STATE_STARTED_LSB = 0;
  localparam int STATE_EXPIRED_LSB = 3;
  localparam int STATE_GEN_START_BIT = 6;
  localparam int STATE_GEN_TRIP_BIT = 7;

  // Interrupt status fields.
  localparam int IRQ_START_BIT = 0;
  localparam int IRQ_TRIP_BIT = 1;
  localparam int IRQ_W = 2;

  // Setting ranges and reset values.
  localparam logic [7:0] RATIO_MIN = 8'h14;
  localparam logic [7:0] RATIO_MAX = 8'h96;
  localparam logic [7:0] RATIO_RST = 8'h64;
  localparam logic [7:0] START_MIN = 8'h14;
  localparam logic [7:0] START_MAX = 8'h64;
  localparam logic [7:0] START_RST = 8'h28;
  localparam logic [7:0] IDLE_MIN = 8'h01;
  localparam logic [7:0] IDLE_MAX = 8'h14;
  localparam logic [7:0] IDLE_RST = 8'h0A;
  localparam logic [15:0] DELAY_MAX = 16'hEA60;
  localparam logic [15:0] DELAY_RST = 16'h0064;
  localparam logic OPER_RST = 1'b1;
  localparam logic STONLY_RST = 1'b0;

  // Release hysteresis: idle boundary scaled by 70/100, upper by 100/95.
  localparam logic [7:0] HYST_SCALE = 8'h64;
  localparam logic [7:0] IDLE_RESET_RATIO = 8'h46;
  localparam logic [7:0] START_RESET_RATIO = 8'h5F;

  typedef enum logic {
    ULP_MODE_OFF,
    ULP_MODE_ON
  } ulp_mode_t;

endpackage

// ==== src/ulp_top.sv ====
// Purpose: Three-phase loss-of-load (undercurrent) start and trip decision.
// Assumes: Phase magnitudes and block_input come from logic on clk.
// Notes: Magnitudes are in units of 0.01 % of the device input rating.
`timescale 1ns/1ps

module ulp_top
  import ulp_pkg::*;
#(
  parameter int TICK_CYCLES = TICK_CYCLES_DEF
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [MAG_W-1:0] mag_l1,
  input wire logic [MAG_W-1:0] mag_l2,
  input wire logic [MAG_W-1:0] mag_l3,
  input wire logic block_input,
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [DATA_W-1:0] reg_rdata,
  output logic general_start_out,
  output logic general_trip_out,
  output logic irq
);

  ////////////////////////////////////////////////////////////////////////////
  // Settings.

  ulp_mode_t operation_mode;
  logic start_only_flag;
  logic [PCT_W-1:0] rating_ratio_pct;
  logic [PCT_W-1:0] start_current_limit_pct;
  logic [PCT_W-1:0] idle_current_limit_pct;
  logic [MS_W-1:0] trip_delay_ms;
  logic [IRQ_W-1:0] irq_stat_reg;
  logic [IRQ_W-1:0] irq_mask_reg;

  // Out-of-range writes are clamped rather than ignored, so software can
  // never leave a setting outside its allowed range.
  function automatic logic [PCT_W-1:0] clamp_pct(
    input logic [DATA_W-1:0] value,
    input logic [PCT_W-1:0] lo,
    input logic [PCT_W-1:0] hi
  );
    logic [PCT_W-1:0] result;
    if (value < DATA_W'(lo)) begin
      result = lo;
    end else if (value > DATA_W'(hi)) begin
      result = hi;
    end else begin
      result = value[PCT_W-1:0];
    end
    return result;
  endfunction

  logic wr_ctrl;
  logic wr_ratio;
  logic wr_start;
  logic wr_idle;
  logic wr_delay;
  logic wr_mask;
  assign wr_ctrl = reg_wr && (reg_addr == OFS_CTRL);
  assign wr_ratio = reg_wr && (reg_addr == OFS_RATIO);
  assign wr_start = reg_wr && (reg_addr == OFS_START);
  assign wr_idle = reg_wr && (reg_addr == OFS_IDLE);
  assign wr_delay = reg_wr && (reg_addr == OFS_DELAY);
  assign wr_mask = reg_wr && (reg_addr == OFS_IRQ_MASK);

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      operation_mode <= ulp_mode_t'(OPER_RST);
      start_only_flag <= STONLY_RST;
    end else if (wr_ctrl) begin
      operation_mode <= reg_wdata[CTRL_OPER_BIT] ? ULP_MODE_ON : ULP_MODE_OFF;
      start_only_flag <= reg_wdata[CTRL_STONLY_BIT];
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rating_ratio_pct <= RATIO_RST;
    end else if (wr_ratio) begin
      rating_ratio_pct <=
        clamp_pct(reg_wdata, RATIO_MIN, RATIO_MAX);
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      start_current_limit_pct <= START_RST;
    end else if (wr_start) begin
      start_current_limit_pct <=
        clamp_pct(reg_wdata, START_MIN, START_MAX);
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      idle_current_limit_pct <= IDLE_RST;
    end else if (wr_idle) begin
      idle_current_limit_pct <=
        clamp_pct(reg_wdata, IDLE_MIN, IDLE_MAX);
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      trip_delay_ms <= DELAY_RST;
    end else if (wr_delay) begin
      if (reg_wdata > DATA_W'(DELAY_MAX)) begin
        trip_delay_ms <= DELAY_MAX;
      end else begin
        trip_delay_ms <= reg_wdata[MS_W-1:0];
      end
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      irq_mask_reg <= '0;
    end else if (wr_mask) begin
      irq_mask_reg <= reg_wdata[IRQ_W-1:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Scaled thresholds, in units of 0.01 % of the input rating.

  logic [THR_W-1:0] start_thr;
  logic [THR_W-1:0] idle_thr;
  logic [CMP_W-1:0] start_rel;
  logic [CMP_W-1:0] idle_rel;
  logic enabled;

  // Registered so the multipliers stay off the comparison path.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      start_thr <= '0;
      idle_thr <= '0;
    end else begin
      // Operands widen first so the product is never cut to eight bits.
      start_thr <= THR_W'(start_current_limit_pct) *
        THR_W'(rating_ratio_pct);
      idle_thr <= THR_W'(idle_current_limit_pct) *
        THR_W'(rating_ratio_pct);
    end
  end

  // Release levels compared against magnitudes multiplied by the scale.
  assign start_rel = CMP_W'(start_thr) * CMP_W'(HYST_SCALE);
  assign idle_rel = CMP_W'(idle_thr) * CMP_W'(IDLE_RESET_RATIO);

  assign enabled = (operation_mode == ULP_MODE_ON) &&
    !block_input;

  ////////////////////////////////////////////////////////////////////////////
  // Millisecond tick.

  localparam int TICK_W = $clog2(TICK_CYCLES + 1);
  logic [TICK_W-1:0] tick_cnt;
  logic tick;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      tick_cnt <= '0;
      tick <= 1'b0;
    end else if (tick_cnt == TICK_W'(TICK_CYCLES - 1)) begin
      tick_cnt <= '0;
      tick <= 1'b1;
    end else begin
      tick_cnt <= tick_cnt + 1'b1;
      tick <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Per-phase start state and delay timer.

  logic [MAG_W-1:0] mag [NUM_PHASES];
  logic [NUM_PHASES-1:0] started;
  logic [NUM_PHASES-1:0] expired;

  assign mag[0] = mag_l1;
  assign mag[1] = mag_l2;
  assign mag[2] = mag_l3;

  typedef enum logic {
    ULP_PH_IDLE,
    ULP_PH_STARTED
  } ulp_phase_t;

  genvar p;
  generate
    for (p = 0; p < NUM_PHASES; p++) begin : g_phase
      ulp_phase_t state_reg;
      ulp_phase_t state_next;
      logic [MS_W-1:0] timer_reg;
      logic pick_up;
      logic drop_out;
      logic [CMP_W-1:0] mag_hi;
      logic [CMP_W-1:0] mag_lo;

      assign mag_hi = CMP_W'(mag[p]) * CMP_W'(START_RESET_RATIO);
      assign mag_lo = CMP_W'(mag[p]) * CMP_W'(HYST_SCALE);
      assign pick_up = (mag[p] > idle_thr) && (mag[p] < start_thr);
      // Hysteresis keeps a phase hovering at a limit from chattering.
      assign drop_out = (mag_lo < idle_rel) || (mag_hi > start_rel);

      always_comb begin
        state_next = state_reg;
        case (state_reg)
          ULP_PH_IDLE: begin
            if (enabled && pick_up) begin
              state_next = ULP_PH_STARTED;
            end
          end
          ULP_PH_STARTED: begin
            if (!enabled || drop_out) begin
              state_next = ULP_PH_IDLE;
            end
          end
          default: begin
            state_next = ULP_PH_IDLE;
          end
        endcase
      end

      always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
          state_reg <= ULP_PH_IDLE;
        end else begin
          state_reg <= state_next;
        end
      end

      // The timer saturates at the delay so it cannot wrap back to zero.
      always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
          timer_reg <= '0;
        end else if (state_reg != ULP_PH_STARTED || !enabled) begin
          timer_reg <= '0;
        end else if (tick && timer_reg < trip_delay_ms) begin
          timer_reg <= timer_reg + 1'b1;
        end
      end

      assign started[p] = (state_reg == ULP_PH_STARTED) && enabled;
      assign expired[p] = started[p] && (timer_reg >= trip_delay_ms);
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // General outputs.

  logic gen_start_next;
  logic gen_trip_next;

  assign gen_start_next = enabled && (&started);
  assign gen_trip_next = enabled && !start_only_flag &&
    (&expired);

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      general_start_out <= 1'b0;
      general_trip_out <= 1'b0;
    end else begin
      general_start_out <= gen_start_next;
      general_trip_out <= gen_trip_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Interrupts: rising edges of the general outputs set sticky bits.

  logic [IRQ_W-1:0] irq_set;
  logic irq_clr;

  always_comb begin
    irq_set = '0;
    irq_set[IRQ_START_BIT] = gen_start_next && !general_start_out;
    irq_set[IRQ_TRIP_BIT] = gen_trip_next && !general_trip_out;
  end

  assign irq_clr = reg_rd && (reg_addr == OFS_IRQ_STAT);

  // A new event in the read cycle survives the clear.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      irq_stat_reg <= '0;
    end else if (irq_clr) begin
      irq_stat_reg <= irq_set;
    end else begin
      irq_stat_reg <= irq_stat_reg | irq_set;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      irq <= 1'b0;
    end else begin
      irq <= |(((irq_stat_reg & ~({IRQ_W{irq_clr}})) | irq_set) &
        irq_mask_reg);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register read port: data stands in the cycle after the read strobe.

  logic [DATA_W-1:0] rd_mux;

  always_comb begin
    rd_mux = '0;
    case (reg_addr)
      OFS_CTRL: begin
        rd_mux[CTRL_OPER_BIT] = (operation_mode == ULP_MODE_ON);
        rd_mux[CTRL_STONLY_BIT] = start_only_flag;
      end
      OFS_RATIO: rd_mux[PCT_W-1:0] = rating_ratio_pct;
      OFS_START: rd_mux[PCT_W-1:0] = start_current_limit_pct;
      OFS_IDLE: rd_mux[PCT_W-1:0] = idle_current_limit_pct;
      OFS_DELAY: rd_mux[MS_W-1:0] = trip_delay_ms;
      OFS_STATE: begin
        rd_mux[STATE_STARTED_LSB +: NUM_PHASES] = started;
        rd_mux[STATE_EXPIRED_LSB +: NUM_PHASES] = expired;
        rd_mux[STATE_GEN_START_BIT] = general_start_out;
        rd_mux[STATE_GEN_TRIP_BIT] = general_trip_out;
      end
      OFS_IRQ_STAT: rd_mux[IRQ_W-1:0] = irq_stat_reg;
      OFS_IRQ_MASK: rd_mux[IRQ_W-1:0] = irq_mask_reg;
      default: rd_mux = '0;
    endcase
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      reg_rdata <= '0;
    end else if (reg_rd) begin
      reg_rdata <= rd_mux;
    end else begin
      reg_rdata <= '0;
    end
  end

endmodule

// ==== verification/ulp_meas_model.sv ====
// Purpose: Measurement stage stand-in feeding per-phase magnitudes.
// Assumes: Magnitudes appear one clock after the bench sets them.
// Notes: No filtering; the bench picks every value directly.
`timescale 1ns/1ps

module ulp_meas_model
  import ulp_pkg::*;
(
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [MAG_W-1:0] set_l1,
  input wire logic [MAG_W-1:0] set_l2,
  input wire logic [MAG_W-1:0] set_l3,
  output logic [MAG_W-1:0] mag_l1,
  output logic [MAG_W-1:0] mag_l2,
  output logic [MAG_W-1:0] mag_l3
);
  // Registered like a real filter output, so the block sees clean levels.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      mag_l1 <= '0;
      mag_l2 <= '0;
      mag_l3 <= '0;
    end else begin
      mag_l1 <= set_l1;
      mag_l2 <= set_l2;
      mag_l3 <= set_l3;
    end
  end
endmodule

// ==== verification/ulp_top_asserts.sv ====
// Purpose: Port-level checks for the undercurrent trip block.
// Assumes: One clock domain, reset rst_b active low.
// Notes: Settings are not visible here, so bands use the widest limits.
`timescale 1ns/1ps

module ulp_top_asserts
  import ulp_pkg::*;
#(
  parameter int TICK_CYCLES = TICK_CYCLES_DEF
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [MAG_W-1:0] mag_l1,
  input wire logic [MAG_W-1:0] mag_l2,
  input wire logic [MAG_W-1:0] mag_l3,
  input wire logic block_input,
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [DATA_W-1:0] reg_rdata,
  input wire logic general_start_out,
  input wire logic general_trip_out,
  input wire logic irq
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  logic stat_rd;
  logic mask_wr;
  logic ctrl_wr;
  assign stat_rd = reg_rd && reg_addr == OFS_IRQ_STAT;
  assign mask_wr = reg_wr && reg_addr == OFS_IRQ_MASK;
  assign ctrl_wr = reg_wr && reg_addr == OFS_CTRL;
  ////////////////////////////////////////////////////////////////////////////
  // Ratio 150 with limit 100 puts the widest drop-out at 15789.
  AST_START_BAND: assert property ($rose(general_start_out) |->
    $past(mag_l1) inside {[16'h0001:16'h3DAD]} &&
    $past(mag_l2) inside {[16'h0001:16'h3DAD]} &&
    $past(mag_l3) inside {[16'h0001:16'h3DAD]})
    else $error("start rose with a phase outside every band");
  AST_BLOCK_START: assert property (block_input |=>
    !general_start_out)
    else $error("start high while blocked");
  AST_BLOCK_TRIP: assert property (block_input |=>
    !general_trip_out)
    else $error("trip high while blocked");
  AST_OFF_QUIET: assert property ((ctrl_wr &&
    !reg_wdata[CTRL_OPER_BIT]) |-> ##[1:3]
    (!general_start_out && !general_trip_out))
    else $error("outputs stay high after mode off");
  AST_STONLY_QUIET: assert property ((ctrl_wr &&
    reg_wdata[CTRL_STONLY_BIT]) |-> ##[1:3] !general_trip_out)
    else $error("trip stays high in start-only mode");
  AST_TRIP_WITH_START: assert property ($rose(general_trip_out) |->
    general_start_out)
    else $error("trip rose without general start");
  AST_RDATA_IDLE: assert property (!$past(reg_rd) |-> reg_rdata == '0)
    else $error("read data outside its cycle");
  AST_MASK_OFF: assert property ((mask_wr && reg_wdata[IRQ_W-1:0] == 2'h0)
    |-> ##[1:2] !irq)
    else $error("irq high with all sources masked");
  AST_IRQ_HOLD: assert property ((irq && !stat_rd && !mask_wr &&
    !$past(stat_rd) && !$past(mask_wr)) |=> irq)
    else $error("irq dropped without a clear");
  COV_START: cover property ($rose(general_start_out));
  COV_TRIP: cover property ($rose(general_trip_out));
  COV_IRQ: cover property ($rose(irq));
endmodule

bind ulp_top ulp_top_asserts #(.TICK_CYCLES(TICK_CYCLES)) ulp_top_asserts_i (
  .clk(clk), .rst_b(rst_b), .mag_l1(mag_l1), .mag_l2(mag_l2),
  .mag_l3(mag_l3), .block_input(block_input), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .general_start_out(general_start_out),
  .general_trip_out(general_trip_out), .irq(irq));

// ==== verification/ulp_top_test.sv ====
// Purpose: Self-checking bench for the undercurrent trip block.
// Assumes: A tick of four clocks stands in for one millisecond.
// Notes: Magnitudes in 0.01 %; default pick-up window is 1001..3999.
`timescale 1ns/1ps
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin \
  miscompares++; $display("[ERR] %0t got %0h exp %0h", $time, g, e); end end

module ulp_top_test
  import ulp_pkg::*;
();
  localparam logic [15:0] MID = 16'h07D0;
  logic clk, rst_b, block_input, reg_wr, reg_rd;
  logic general_start_out, general_trip_out, irq;
  logic [MAG_W-1:0] s1, s2, s3, m1, m2, m3;
  logic [ADDR_W-1:0] reg_addr;
  logic [DATA_W-1:0] reg_wdata, reg_rdata;
  int miscompares, check_count, n;
  logic [7:0] ra [9] = '{OFS_CTRL, OFS_RATIO, OFS_START, OFS_IDLE,
    OFS_DELAY, OFS_STATE, OFS_IRQ_STAT, OFS_IRQ_MASK, 8'h20};
  logic [31:0] rv [9] = '{32'h1, 32'h64, 32'h28, 32'hA, 32'h64, 32'h0,
    32'h0, 32'h0, 32'h0};
  logic [7:0] ca [8] = '{OFS_RATIO, OFS_RATIO, OFS_START, OFS_START,
    OFS_IDLE, OFS_IDLE, OFS_DELAY, OFS_STATE};
  logic [31:0] cw [8] = '{32'hA, 32'hC8, 32'h5, 32'hC8, 32'h0, 32'h1E,
    32'hFFFF, 32'hFF};
  logic [31:0] ce [8] = '{32'h14, 32'h96, 32'h14, 32'h64, 32'h1, 32'h14,
    32'hEA60, 32'h0};
  logic [15:0] w1 [5] = '{MID, 16'h03E8, 16'h03E9, MID, MID};
  logic [15:0] w2 [5] = '{MID, MID, 16'h0F9F, 16'h0FA0, MID};
  logic [15:0] w3 [5] = '{MID, MID, MID, MID, 16'h01F4};
  logic we [5] = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b0};

  ulp_meas_model ulp_meas_model_i (.clk(clk), .rst_b(rst_b),
    .set_l1(s1), .set_l2(s2), .set_l3(s3),
    .mag_l1(m1), .mag_l2(m2), .mag_l3(m3));
  ulp_top #(.TICK_CYCLES(4)) ulp_top_i (.clk(clk), .rst_b(rst_b),
    .mag_l1(m1), .mag_l2(m2), .mag_l3(m3), .block_input(block_input),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .general_start_out(general_start_out),
    .general_trip_out(general_trip_out), .irq(irq));

  ////////////////////////////////////////////////////////////////////////////
  task cyc(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task rdc(input logic [7:0] a, input logic [31:0] e);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    `CHK(reg_rdata, e)
  endtask
  task mg(input logic [15:0] a, input logic [15:0] b, input logic [15:0] c);
    @(posedge clk);
    s1 <= a;
    s2 <= b;
    s3 <= c;
  endtask
  task outs(input logic es, input logic et);
    `CHK(general_start_out, es)
    `CHK(general_trip_out, et)
  endtask
  task tdone(input string s);
    $display("test %s done", s);
  endtask
  task final_report;
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  // Whole run is about 330 clocks; a hang shows long before this.
  initial begin
    repeat (20000) @(posedge clk);
    miscompares++;
    final_report;
  end
  initial begin
    rst_b = 1'b0;
    block_input = 1'b0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = '0;
    reg_wdata = '0;
    s1 = '0;
    s2 = '0;
    s3 = '0;
    miscompares = 0;
    check_count = 0;
    repeat (16) @(posedge clk);
    rst_b <= 1'b1;
    for (int i = 0; i < 9; i++) begin
      rdc(ra[i], rv[i]);
    end
    tdone("reset");
    for (int i = 0; i < 8; i++) begin
      wr(ca[i], cw[i]);
      rdc(ca[i], ce[i]);
    end
    wr(OFS_RATIO, 32'h64);
    wr(OFS_START, 32'h28);
    wr(OFS_IDLE, 32'hA);
    wr(OFS_DELAY, 32'h64);
    tdone("limits");
    for (int i = 0; i < 5; i++) begin
      mg(w1[i], w2[i], w3[i]);
      cyc(6);
      `CHK(general_start_out, we[i])
      mg(16'h0, 16'h0, 16'h0);
      cyc(4);
    end
    tdone("window");
    mg(MID, MID, MID);
    cyc(6);
    mg(16'h0320, 16'h1068, MID);
    cyc(6);
    outs(1'b1, 1'b0);
    mg(16'h028A, 16'h1068, MID);
    cyc(6);
    outs(1'b0, 1'b0);
    mg(MID, MID, MID);
    cyc(6);
    mg(MID, 16'h10CC, MID);
    cyc(6);
    outs(1'b0, 1'b0);
    tdone("release");
    wr(OFS_RATIO, 32'h32);
    mg(16'h09C4, 16'h09C4, 16'h09C4);
    cyc(6);
    outs(1'b0, 1'b0);
    mg(16'h05DC, 16'h05DC, 16'h05DC);
    cyc(6);
    outs(1'b1, 1'b0);
    mg(16'h0, 16'h0, 16'h0);
    wr(OFS_RATIO, 32'h64);
    rdc(OFS_IRQ_STAT, 32'h1);
    rdc(OFS_IRQ_STAT, 32'h0);
    tdone("ratio");
    wr(OFS_DELAY, 32'h3);
    wr(OFS_IRQ_MASK, 32'h3);
    mg(MID, MID, MID);
    for (n = 0; n < 20 && general_start_out !== 1'b1; n++) cyc(1);
    cyc(5);
    outs(1'b1, 1'b0);
    `CHK(irq, 1'b1)
    for (n = 0; n < 30 && general_trip_out !== 1'b1; n++) cyc(1);
    outs(1'b1, 1'b1);
    rdc(OFS_STATE, 32'hFF);
    rdc(OFS_IRQ_STAT, 32'h3);
    rdc(OFS_IRQ_STAT, 32'h0);
    `CHK(irq, 1'b0)
    mg(16'h01F4, MID, MID);
    cyc(4);
    outs(1'b0, 1'b0);
    mg(MID, MID, MID);
    cyc(8);
    outs(1'b1, 1'b0);
    tdone("timer");
    wr(OFS_CTRL, 32'h3);
    cyc(30);
    outs(1'b1, 1'b0);
    wr(OFS_CTRL, 32'h0);
    cyc(4);
    outs(1'b0, 1'b0);
    wr(OFS_CTRL, 32'h1);
    cyc(30);
    outs(1'b1, 1'b1);
    @(posedge clk);
    block_input <= 1'b1;
    cyc(3);
    outs(1'b0, 1'b0);
    @(posedge clk);
    block_input <= 1'b0;
    cyc(8);
    outs(1'b1, 1'b0);
    tdone("disable");
    `CHK(irq, 1'b1)
    wr(OFS_IRQ_MASK, 32'h0);
    cyc(3);
    `CHK(irq, 1'b0)
    rdc(OFS_IRQ_MASK, 32'h0);
    tdone("irq");
    final_report;
  end
endmodule
